// ==== common/iofc_map.svh ====
// Purpose: register offsets and reset values of the io line controller
// Assumes: byte addresses on an 8-bit register address
// Notes:   all registers are 32 bits wide, one bit per io line
`ifndef IOFC_MAP_SVH
`define IOFC_MAP_SVH

`define IOFC_AW         8
`define IOFC_DW         32
`define IOFC_A_OER      8'h10
`define IOFC_A_ODR      8'h14
`define IOFC_A_OSR      8'h18
`define IOFC_A_IFER     8'h20
`define IOFC_A_IFDR     8'h24
`define IOFC_A_IFSR     8'h28
`define IOFC_A_SET      8'h30
`define IOFC_A_CLR      8'h34
`define IOFC_A_ODSR     8'h38
`define IOFC_A_LVL      8'h3C
`define IOFC_A_IER      8'h40
`define IOFC_A_IDR      8'h44
`define IOFC_A_IMR      8'h48
`define IOFC_A_ISR      8'h4C
`define IOFC_A_MDER     8'h50
`define IOFC_A_MDSR     8'h58
`define IOFC_RST        32'h0000_0000
`define IOFC_ONES       32'hFFFF_FFFF

`endif

// ==== common/iofc_pkg.sv ====
// Purpose: state type of the io line controller
// Assumes: 32 io lines
// Notes:   every field but irq holds one bit per line
package iofc_pkg;

    typedef struct packed {
        logic [31:0] drv;
        logic [31:0] filt;
        logic [31:0] out;
        logic [31:0] imr;
        logic [31:0] isr;
        logic [31:0] od;
        logic [31:0] level;
        logic [31:0] raw_q;
        logic [31:0] rdata;
        logic [31:0] pad_out;
        logic [31:0] pad_oe;
        logic        irq;
    } iofc_state_t;

endpackage

// ==== sim/iofc_ctrl_bench.sv ====
// Purpose: self-checking bench of the io line controller
// Assumes: 125 MHz core clock, strobe register bus
// Notes:   board levels come from ext through the pad model
`include "iofc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module iofc_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] permit;
    logic [31:0] ext;
    logic [31:0] level;
    logic [31:0] rdata;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
    logic        irq;
    int          fail_count = 0;
    int          n_checks = 0;

    iofc_ctrl iofc_ctrl_i (.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .direct_write_permit_i(permit), .pad_in_i(level), .rdata_o(rdata), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .irq_o(irq));
    iofc_pad_model iofc_pad_model_i (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .level_o(level));

    always #4 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask

    task automatic pulse(input int line);
        @(posedge clk);
        ext[line] <= 1'b1;
        @(posedge clk);
        ext[line] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk(`IOFC_A_OSR, `IOFC_RST, "driver status");
        rchk(`IOFC_A_IFSR, `IOFC_RST, "filter status");
        rchk(`IOFC_A_IMR, `IOFC_RST, "irq mask");
        rchk(`IOFC_A_ISR, `IOFC_RST, "irq status");
        rchk(8'h1C, `IOFC_RST, "unmapped");
    endtask

    task automatic t_output();
        wreg(`IOFC_A_OER, `IOFC_ONES);
        wreg(`IOFC_A_SET, 32'h0000_00FF);
        wreg(`IOFC_A_CLR, 32'h0000_000F);
        rchk(`IOFC_A_ODSR, 32'h0000_00F0, "set clear");
        wreg(`IOFC_A_ODR, 32'hFFFF_0000);
        rchk(`IOFC_A_OSR, 32'h0000_FFFF, "driver off");
        check("pad enable", pad_oe, 32'h0000_FFFF);
        wreg(`IOFC_A_SET, 32'h0001_0000);
        rchk(`IOFC_A_ODSR, 32'h0001_00F0, "undriven data");
        rchk(`IOFC_A_LVL, 32'h0000_00F0, "line level");
        wreg(`IOFC_A_ODSR, `IOFC_ONES);
        rchk(`IOFC_A_ODSR, 32'h0001_FFF0, "permit write");
    endtask

    task automatic t_open_drain();
        wreg(`IOFC_A_MDER, 32'h0000_0011);
        #1;
        check("od enable", pad_oe & 32'h0000_0011, 32'h0000_0001);
        check("od value", pad_out & 32'h0000_0011, 32'h0000_0000);
        rchk(`IOFC_A_ODSR, 32'h0001_FFF0, "od data");
        rchk(`IOFC_A_MDSR, 32'h0000_0011, "od status");
    endtask

    // line 31 stays high at the board across a reset
    task automatic t_rst_change();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rchk(`IOFC_A_OSR, `IOFC_RST, "driver after reset");
        rchk(`IOFC_A_ISR, 32'h8000_0000, "change after reset");
        rchk(`IOFC_A_ISR, `IOFC_RST, "second status read");
    endtask

    task automatic t_irq();
        rchk(`IOFC_A_ISR, 32'h0000_FFFF, "od change");
        rchk(`IOFC_A_ISR, `IOFC_RST, "cleared");
        wreg(`IOFC_A_IER, 32'h8000_0001);
        rchk(`IOFC_A_IMR, 32'h8000_0001, "mask on");
        check("irq idle", {31'h0, irq}, 32'h0);
        @(posedge clk);
        ext[31] <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("irq raised", {31'h0, irq}, 32'h1);
        rchk(`IOFC_A_ISR, 32'h8000_0000, "change seen");
        rchk(`IOFC_A_ISR, `IOFC_RST, "read clears");
        check("irq cleared", {31'h0, irq}, 32'h0);
        wreg(`IOFC_A_IDR, 32'h8000_0000);
        rchk(`IOFC_A_IMR, 32'h0000_0001, "mask off");
    endtask

    task automatic t_filter();
        wreg(`IOFC_A_IFER, 32'h4000_0000);
        rchk(`IOFC_A_IFSR, 32'h4000_0000, "filter on");
        pulse(30);
        rchk(`IOFC_A_ISR, `IOFC_RST, "glitch dropped");
        wreg(`IOFC_A_IFDR, 32'h4000_0000);
        rchk(`IOFC_A_IFSR, `IOFC_RST, "filter off");
        pulse(30);
        rchk(`IOFC_A_ISR, 32'h4000_0000, "glitch seen");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        {addr, wdata, wr, rd, ext} = '0;
        permit = 32'h0000_FF00;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_output();
        t_open_drain();
        t_irq();
        t_filter();
        t_rst_change();
        results();
    end

    // the sequence needs about 110 cycles
    initial
    begin
        #40000;
        fail_count++;
        results();
    end
endmodule

`default_nettype wire

// ==== sim/iofc_pad_model.sv ====
// Purpose: pad ring model seen by the io line controller
// Assumes: board drivers act only on lines whose controller pad output enable is off
// Notes:   a released line shows the board level
`timescale 1ns/10ps
`default_nettype none

module iofc_pad_model
(
    input  wire logic [31:0] pad_out_i,
    input  wire logic [31:0] pad_oe_i,
    input  wire logic [31:0] ext_i,
    output logic      [31:0] level_o
);
    // driven lines follow the controller, released lines the board
    assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

`default_nettype wire

// ==== src/iofc_ctrl.sv ====
// Purpose: per-line output, glitch filter and change interrupt control
// Assumes: pad inputs synchronous to core_clk_i; 125 MHz clock
// Notes:   read data valid in the cycle after the read strobe only
//
// Summary of operation
// R1 - writing 1 to output_driver_disable turns that line's driver off
// R2 - output_driver_status reads 1 for driven lines, 0 for input only
// R3 - writing 1 to glitch_filter_enable turns that line's filter on
// R4 - writing 1 to glitch_filter_disable turns that line's filter off
// R5 - glitch_filter_status reads 1 where the filter is on
// R6 - writing 1 to output_value_set makes that line's stored output 1
// R7 - writing 1 to output_value_clear makes that line's stored output 0
// R8 - output_value_status reads stored output, driver enabled or not
// R9 - output_value_status always readable, writable per line
// R10 - direct output_value_status write changes only permitted lines
// R11 - line_level_status reads the actual level on each line
// R12 - writing 1 to change_irq_enable enables that line's interrupt
// R13 - writing 1 to change_irq_disable disables that line's interrupt
// R14 - change_irq_mask reads 1 where the interrupt is enabled
// R15 - a level change sets the line's status bit until status is read
// R16 - reading change_irq_status clears all bits except those of lines changing in that cycle
// R17 - first status read after reset may show changes already seen
// R18 - writing 1 to open_drain_enable puts that line in open drain
// R19 - open drain lines only pull low, others drive both levels
// R20 - bit n is line n; interrupt while status and mask both set
// R21 - with filter on, single cycle pulses are ignored
`include "iofc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module iofc_ctrl
(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [`IOFC_AW-1:0]    addr_i,
    input  wire logic [`IOFC_DW-1:0]    wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire logic [`IOFC_DW-1:0]    direct_write_permit_i,
    input  wire logic [`IOFC_DW-1:0]    pad_in_i,
    output logic      [`IOFC_DW-1:0]    rdata_o,
    output logic      [`IOFC_DW-1:0]    pad_out_o,
    output logic      [`IOFC_DW-1:0]    pad_oe_o,
    output logic                        irq_o
);

    iofc_pkg::iofc_state_t st;
    iofc_pkg::iofc_state_t next_st;

    logic [`IOFC_DW-1:0] upd;
    logic [`IOFC_DW-1:0] change;
    logic [`IOFC_DW-1:0] isr_clr;

    function automatic logic [31:0] set_clr
    (
        input logic [31:0] cur,
        input logic [31:0] set,
        input logic [31:0] clr
    );
        set_clr = (cur | set) & ~clr;
    endfunction

    function automatic logic wr_at
    (
        input logic                wr,
        input logic [`IOFC_AW-1:0] a,
        input logic [`IOFC_AW-1:0] target
    );
        wr_at = wr && (a == target);
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.rdata = `IOFC_RST;
        // driver state
        next_st.drv = set_clr(st.drv,
                              wr_at(wr_i, addr_i, `IOFC_A_OER) ? wdata_i : `IOFC_RST,
                              wr_at(wr_i, addr_i, `IOFC_A_ODR) ? wdata_i : `IOFC_RST); // R1
        next_st.filt = set_clr(st.filt,
                               wr_at(wr_i, addr_i, `IOFC_A_IFER) ? wdata_i : `IOFC_RST, // R3
                               wr_at(wr_i, addr_i, `IOFC_A_IFDR) ? wdata_i : `IOFC_RST); // R4
        next_st.out = set_clr(st.out,
                              wr_at(wr_i, addr_i, `IOFC_A_SET) ? wdata_i : `IOFC_RST, // R6
                              wr_at(wr_i, addr_i, `IOFC_A_CLR) ? wdata_i : `IOFC_RST); // R7
        if (wr_at(wr_i, addr_i, `IOFC_A_ODSR))
        begin
            next_st.out = (st.out & ~direct_write_permit_i)
                        | (wdata_i & direct_write_permit_i); // R9 R10
        end
        next_st.imr = set_clr(st.imr,
                              wr_at(wr_i, addr_i, `IOFC_A_IER) ? wdata_i : `IOFC_RST, // R12
                              wr_at(wr_i, addr_i, `IOFC_A_IDR) ? wdata_i : `IOFC_RST); // R13
        if (wr_at(wr_i, addr_i, `IOFC_A_MDER))
        begin
            next_st.od = st.od | wdata_i; // R18
        end
        // glitch filter: a filtered line follows the pad only after two equal samples
        upd = ~st.filt | ~(pad_in_i ^ st.raw_q); // R21
        next_st.raw_q = pad_in_i;
        next_st.level = (st.level & ~upd) | (pad_in_i & upd); // R11
        change = next_st.level ^ st.level;
        // a change in the clearing cycle survives the read
        isr_clr = (rd_i && addr_i == `IOFC_A_ISR) ? `IOFC_ONES : `IOFC_RST; // R16
        next_st.isr = (st.isr & ~isr_clr) | change; // R15 R17
        if (rd_i)
        begin
            case (addr_i)
                `IOFC_A_OSR:  next_st.rdata = st.drv; // R2
                `IOFC_A_IFSR: next_st.rdata = st.filt; // R5
                `IOFC_A_ODSR: next_st.rdata = st.out; // R8 R9
                `IOFC_A_LVL:  next_st.rdata = st.level; // R11
                `IOFC_A_IMR:  next_st.rdata = st.imr; // R14
                `IOFC_A_ISR:  next_st.rdata = st.isr; // R16
                `IOFC_A_MDSR: next_st.rdata = st.od;
                default:      next_st.rdata = `IOFC_RST;
            endcase
        end
        // open drain lines drive low only, released when the value is 1
        next_st.pad_out = next_st.out & ~next_st.od; // R19
        next_st.pad_oe = next_st.drv & ~(next_st.od & next_st.out); // R19
        next_st.irq = |(next_st.isr & next_st.imr); // R20
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign pad_out_o = st.pad_out;
    assign pad_oe_o = st.pad_oe;
    assign irq_o = st.irq;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    drv_disable_a: assert property ( // R1
        wr_i && addr_i == `IOFC_A_ODR |=> (st.drv & $past(wdata_i)) == `IOFC_RST)
        else $error("output driver not turned off");

    drv_status_a: assert property ( // R2
        rd_i && addr_i == `IOFC_A_OSR |=> rdata_o == $past(st.drv))
        else $error("driver status read wrong");

    filt_enable_a: assert property ( // R3
        wr_i && addr_i == `IOFC_A_IFER |=> (~st.filt & $past(wdata_i)) == `IOFC_RST)
        else $error("filter not turned on");

    filt_disable_a: assert property ( // R4
        wr_i && addr_i == `IOFC_A_IFDR |=> (st.filt & $past(wdata_i)) == `IOFC_RST)
        else $error("filter not turned off");

    filt_status_a: assert property ( // R5
        rd_i && addr_i == `IOFC_A_IFSR |=> rdata_o == $past(st.filt))
        else $error("filter status read wrong");

    out_set_a: assert property ( // R6
        wr_i && addr_i == `IOFC_A_SET |=> st.out == ($past(st.out) | $past(wdata_i)))
        else $error("output set wrong");

    out_clear_a: assert property ( // R7
        wr_i && addr_i == `IOFC_A_CLR |=> st.out == ($past(st.out) & ~$past(wdata_i)))
        else $error("output clear wrong");

    out_status_a: assert property ( // R8
        rd_i && addr_i == `IOFC_A_ODSR |=> rdata_o == $past(st.out))
        else $error("output value read wrong");

    direct_write_a: assert property ( // R10
        wr_i && addr_i == `IOFC_A_ODSR |=>
        ((st.out ^ $past(st.out)) & ~$past(direct_write_permit_i)) == `IOFC_RST)
        else $error("unpermitted line changed");

    level_read_a: assert property ( // R11
        rd_i && addr_i == `IOFC_A_LVL |=> rdata_o == $past(st.level))
        else $error("line level read wrong");

    irq_mask_a: assert property ( // R12
        wr_i && addr_i == `IOFC_A_IER
        |=> (~st.imr & $past(wdata_i)) == `IOFC_RST)
        else $error("interrupt enable not seen in mask");

    irq_disable_a: assert property ( // R13
        wr_i && addr_i == `IOFC_A_IDR |=> (st.imr & $past(wdata_i)) == `IOFC_RST)
        else $error("interrupt not disabled");

    change_sets_a: assert property ( // R15
        ((st.level ^ $past(st.level)) & ~st.isr) == `IOFC_RST)
        else $error("change did not set status");

    read_clears_a: assert property ( // R16
        rd_i && addr_i == `IOFC_A_ISR |=>
        (st.isr & ~(st.level ^ $past(st.level))) == `IOFC_RST)
        else $error("status not cleared by read");

    od_enable_a: assert property ( // R18
        wr_i && addr_i == `IOFC_A_MDER |=> (~st.od & $past(wdata_i)) == `IOFC_RST)
        else $error("open drain not enabled");

    od_low_only_a: assert property ( // R19
        (st.od & pad_oe_o & st.out) == `IOFC_RST && (st.od & pad_out_o) == `IOFC_RST)
        else $error("open drain line driven high");

    irq_level_a: assert property ( // R20
        irq_o == |(st.isr & st.imr))
        else $error("interrupt output wrong");

    glitch_reject_a: assert property ( // R21
        ((st.level ^ $past(st.level)) & $past(st.filt)
         & ($past(pad_in_i) ^ $past(pad_in_i, 2))) == `IOFC_RST)
        else $error("filtered line took a one cycle pulse");

    drv_enable_a: assert property ( // R2
        wr_i && addr_i == `IOFC_A_OER
        |=> (~st.drv & $past(wdata_i)) == `IOFC_RST)
        else $error("output driver not turned on");

    drv_keep_a: assert property ( // R1
        wr_i && addr_i == `IOFC_A_ODR
        |=> ((st.drv ^ $past(st.drv)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("driver of unwritten line changed");

    drv_stable_a: assert property ( // R1
        !(wr_i && (addr_i == `IOFC_A_OER || addr_i == `IOFC_A_ODR))
        |=> st.drv == $past(st.drv))
        else $error("driver state changed without write");

    filt_keep_on_a: assert property ( // R3
        wr_i && addr_i == `IOFC_A_IFER
        |=> ((st.filt ^ $past(st.filt)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("filter of unwritten line changed");

    filt_keep_off_a: assert property ( // R4
        wr_i && addr_i == `IOFC_A_IFDR
        |=> ((st.filt ^ $past(st.filt)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("filter of unwritten line changed");

    filt_stable_a: assert property ( // R5
        !(wr_i && (addr_i == `IOFC_A_IFER || addr_i == `IOFC_A_IFDR))
        |=> st.filt == $past(st.filt))
        else $error("filter state changed without write");

    rdata_idle_a: assert property ( // R2
        !rd_i
        |=> rdata_o == `IOFC_RST)
        else $error("read data outside read cycle");

    wo_read_zero_a: assert property ( // R1
        rd_i && addr_i == `IOFC_A_ODR
        |=> rdata_o == `IOFC_RST)
        else $error("write only register read nonzero");

    out_keep_set_a: assert property ( // R6
        wr_i && addr_i == `IOFC_A_SET
        |=> ((st.out ^ $past(st.out)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("set touched unwritten line");

    out_keep_clr_a: assert property ( // R7
        wr_i && addr_i == `IOFC_A_CLR
        |=> ((st.out ^ $past(st.out)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("clear touched unwritten line");

    out_stable_a: assert property ( // R8
        !(wr_i && (addr_i == `IOFC_A_SET || addr_i == `IOFC_A_CLR || addr_i == `IOFC_A_ODSR))
        |=> st.out == $past(st.out))
        else $error("stored output changed without write");

    direct_take_a: assert property ( // R10
        wr_i && addr_i == `IOFC_A_ODSR
        |=> ((st.out ^ $past(wdata_i)) & $past(direct_write_permit_i)) == `IOFC_RST)
        else $error("permitted line not written");

    out_indep_drv_a: assert property ( // R8
        wr_i && addr_i == `IOFC_A_ODR
        |=> st.out == $past(st.out))
        else $error("driver disable changed stored output");

    imr_keep_en_a: assert property ( // R12
        wr_i && addr_i == `IOFC_A_IER
        |=> ((st.imr ^ $past(st.imr)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("mask of unwritten line changed");

    imr_keep_dis_a: assert property ( // R13
        wr_i && addr_i == `IOFC_A_IDR
        |=> ((st.imr ^ $past(st.imr)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("mask of unwritten line changed");

    imr_stable_a: assert property ( // R14
        !(wr_i && (addr_i == `IOFC_A_IER || addr_i == `IOFC_A_IDR))
        |=> st.imr == $past(st.imr))
        else $error("mask changed without write");

    mask_read_a: assert property ( // R14
        rd_i && addr_i == `IOFC_A_IMR
        |=> rdata_o == $past(st.imr))
        else $error("mask read wrong");

    status_read_a: assert property ( // R16
        rd_i && addr_i == `IOFC_A_ISR
        |=> rdata_o == $past(st.isr))
        else $error("status read wrong");

    status_hold_a: assert property ( // R15
        !(rd_i && addr_i == `IOFC_A_ISR)
        |=> (~st.isr & $past(st.isr)) == `IOFC_RST)
        else $error("status bit lost without read");

    status_cause_a: assert property ( // R15
        ((st.isr & ~$past(st.isr))
         & ~(st.level ^ $past(st.level))) == `IOFC_RST)
        else $error("status set without change");

    od_keep_a: assert property ( // R18
        wr_i && addr_i == `IOFC_A_MDER
        |=> ((st.od ^ $past(st.od)) & ~$past(wdata_i)) == `IOFC_RST)
        else $error("open drain of unwritten line changed");

    od_stable_a: assert property ( // R18
        !(wr_i && addr_i == `IOFC_A_MDER)
        |=> st.od == $past(st.od))
        else $error("open drain changed without write");

    od_read_a: assert property ( // R18
        rd_i && addr_i == `IOFC_A_MDSR
        |=> rdata_o == $past(st.od))
        else $error("open drain status read wrong");

    push_pull_value_a: assert property ( // R19
        (pad_out_o & ~st.od)
        == (st.out & ~st.od))
        else $error("push pull line value wrong");

    push_pull_enable_a: assert property ( // R19
        (pad_oe_o & ~st.od)
        == (st.drv & ~st.od))
        else $error("push pull line enable wrong");

    od_pull_low_a: assert property ( // R19
        (pad_oe_o & st.od)
        == (st.drv & st.od & ~st.out))
        else $error("open drain line not pulled low");

    undriven_off_a: assert property ( // R2
        (pad_oe_o & ~st.drv)
        == `IOFC_RST)
        else $error("input only line driven");

    irq_low_a: assert property ( // R20
        (st.isr & st.imr) == `IOFC_RST
        |-> !irq_o)
        else $error("interrupt without masked status");

    level_follow_a: assert property ( // R11
        $past(rst_b_i)
        |-> (~$past(st.filt) & (st.level ^ $past(pad_in_i))) == `IOFC_RST)
        else $error("unfiltered level not following line");

    level_filt_take_a: assert property ( // R21
        $past(rst_b_i)
        |-> ($past(st.filt) & ~($past(pad_in_i) ^ $past(st.raw_q)) & (st.level ^ $past(pad_in_i))) == `IOFC_RST)
        else $error("filtered level missed steady input");

    raw_track_a: assert property ( // R21
        $past(rst_b_i)
        |-> st.raw_q == $past(pad_in_i))
        else $error("filter sample not taken");

endmodule

`default_nettype wire
